/* hw/dual_timer_interrupt_control.sv */
/*
 * Two interval timers with control registers A and B and the interrupt
 * status/mask register, reached over an AXI4-Lite slave.
 * Assumes count_input_pin and handshake_flag_input are asynchronous pins,
 * serial_event is a one-cycle pulse from the serial shifter on aclk.
 */
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps

`include "dual_timer_map.svh"

module dual_timer_interrupt_control #(
    parameter int ADDR_W = 18
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Pins and neighbour events
    input wire logic count_input_pin,
    input wire logic handshake_flag_input,
    input wire logic serial_event,
    // Outputs to pins and neighbouring blocks
    output logic timer_a_output_pin,
    output logic timer_a_output_pin_oe,
    output logic timer_b_output_pin,
    output logic timer_b_output_pin_oe,
    output logic tod_freq_50hz,
    output logic serial_port_output,
    output logic tod_write_alarm
);
    import dual_timer_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg8_t ctl_a, next_ctl_a, ctl_b, next_ctl_b;
    word16_t latch_a, next_latch_a, latch_b, next_latch_b;
    int_bits_t flags, next_flags, mask, next_mask;
    logic load_a, next_load_a, load_b, next_load_b;
    logic [15:0] wr_idx, next_wr_idx;
    logic [31:0] wr_data, next_wr_data;
    logic [3:0] wr_strb, next_wr_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic cnt_meta, cnt_sync, cnt_prev, flag_meta, flag_sync, flag_prev;
    logic cnt_rise, flag_fall, write_go, read_go, icr_read, any_pending;
    logic ev_a, ev_b, under_a, under_b;
    logic [15:0] rd_idx;
    word16_t count_a, count_b;
    b_source_t src_b;

    // ----------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------
    // Two stages before use; edges are taken only from the settled stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_meta <= 1'b0;
            cnt_sync <= 1'b0;
            cnt_prev <= 1'b0;
            flag_meta <= 1'b1;
            flag_sync <= 1'b1;
            flag_prev <= 1'b1;
        end else begin
            cnt_meta <= count_input_pin;
            cnt_sync <= cnt_meta;
            cnt_prev <= cnt_sync;
            flag_meta <= handshake_flag_input;
            flag_sync <= flag_meta;
            flag_prev <= flag_sync;
        end
    end

    assign cnt_rise = cnt_sync && !cnt_prev;
    assign flag_fall = !flag_sync && flag_prev; // Handshake line is active low

    // ----------------------------------------
    // Count sources
    // ----------------------------------------
    // Timer B cascades from A one cycle after A's underflow flop
    assign src_b = b_source_t'(ctl_b[`CTL_B_SRC_HI:`CTL_B_SRC_LO]);
    assign ev_a = ctl_a[`CTL_A_CNT_SRC] ? cnt_rise : 1'b1;
    always_comb begin
        unique case (src_b)
            SRC_CLOCK: ev_b = 1'b1;
            SRC_CNT_PIN: ev_b = cnt_rise;
            SRC_TA_UNDER: ev_b = under_a;
            SRC_TA_UNDER_CNT: ev_b = under_a && cnt_sync;
        endcase
    end

    // Timer A
    interval_timer #(.WIDTH(16)) timer_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(ctl_a[`CTL_START]),
        .force_load(load_a),
        .toggle_mode(ctl_a[`CTL_TOGGLE]),
        .count_event(ev_a),
        .reload_value(latch_a),
        .count(count_a),
        .underflow(under_a),
        .pin_level(timer_a_output_pin)
    );

    // Timer B, same control meanings as A
    interval_timer #(.WIDTH(16)) timer_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(ctl_b[`CTL_START]),
        .force_load(load_b),
        .toggle_mode(ctl_b[`CTL_TOGGLE]),
        .count_event(ev_b),
        .reload_value(latch_b),
        .count(count_b),
        .underflow(under_b),
        .pin_level(timer_b_output_pin)
    );

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign write_go = !awready && !wready && !bvalid;
    assign read_go = arvalid && arready;
    assign rd_idx = 16'(araddr[ADDR_W-1:2]);
    assign icr_read = read_go && (rd_idx == `IDX_INT_STATUS_MASK);
    // Handshake flag counts regardless of the mask
    assign any_pending = |(flags & (mask | `INT_NON_MASKABLE));

    // ----------------------------------------
    // Register and bus next state
    // ----------------------------------------
    always_comb begin
        next_ctl_a = ctl_a;
        next_ctl_b = ctl_b;
        next_latch_a = latch_a;
        next_latch_b = latch_b;
        next_flags = flags;
        next_mask = mask;
        next_load_a = 1'b0;
        next_load_b = 1'b0;
        next_wr_idx = wr_idx;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        next_awready = awready;
        next_wready = wready;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_arready = arready;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;

        // Address and data may arrive in either order
        if (awvalid && awready) begin
            next_wr_idx = 16'(awaddr[ADDR_W-1:2]);
            next_awready = 1'b0;
        end
        if (wvalid && wready) begin
            next_wr_data = wdata;
            next_wr_strb = wstrb;
            next_wready = 1'b0;
        end

        // Write into the register file once both halves are held
        if (write_go) begin
            next_bvalid = 1'b1;
            next_bresp = `RESP_OKAY;
            unique case (wr_idx)
                `IDX_TIMER_CONTROL_A: if (wr_strb[0]) begin
                    next_ctl_a = wr_data[7:0] & ~8'h10; // Force load is a strobe
                    next_load_a = wr_data[`CTL_FORCE_LOAD];
                end
                `IDX_TIMER_CONTROL_B: if (wr_strb[0]) begin
                    next_ctl_b = wr_data[7:0] & ~8'h10;
                    next_load_b = wr_data[`CTL_FORCE_LOAD];
                end
                `IDX_INT_STATUS_MASK: if (wr_strb[0]) begin
                    // Writes touch only the mask, never the flags
                    for (int i = 0; i < 5; i++) begin
                        if (wr_data[i]) begin
                            next_mask[i] = wr_data[`INT_ANY];
                        end
                    end
                end
                `IDX_TIMER_LATCH_A: begin
                    if (wr_strb[0]) next_latch_a[7:0] = wr_data[7:0];
                    if (wr_strb[1]) next_latch_a[15:8] = wr_data[15:8];
                end
                `IDX_TIMER_LATCH_B: begin
                    if (wr_strb[0]) next_latch_b[7:0] = wr_data[7:0];
                    if (wr_strb[1]) next_latch_b[15:8] = wr_data[15:8];
                end
                default: next_bresp = `RESP_SLVERR;
            endcase
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
            next_awready = 1'b1;
            next_wready = 1'b1;
        end

        // Read path; interrupt flags clear as they are read
        if (read_go) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rresp = `RESP_OKAY;
            next_rdata = 32'h0000_0000;
            unique case (rd_idx)
                `IDX_TIMER_CONTROL_A: next_rdata[7:0] = ctl_a;
                `IDX_TIMER_CONTROL_B: next_rdata[7:0] = ctl_b;
                `IDX_TIMER_LATCH_A: next_rdata[15:0] = count_a;
                `IDX_TIMER_LATCH_B: next_rdata[15:0] = count_b;
                `IDX_INT_STATUS_MASK: begin
                    next_rdata[7:0] = {any_pending, 2'b00, flags};
                    next_flags = `INT_RESET;
                end
                default: next_rresp = `RESP_SLVERR;
            endcase
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end

        // Events set flags after any clear so a set in the same cycle wins
        if (under_a) next_flags[`INT_TIMER_A] = 1'b1;
        if (under_b) next_flags[`INT_TIMER_B] = 1'b1;
        if (serial_event) next_flags[`INT_SERIAL] = 1'b1;
        if (flag_fall) next_flags[`INT_HANDSHAKE] = 1'b1;

        // One-shot timers stop themselves after underflow
        if (under_a && ctl_a[`CTL_ONE_SHOT]) next_ctl_a[`CTL_START] = 1'b0;
        if (under_b && ctl_b[`CTL_ONE_SHOT]) next_ctl_b[`CTL_START] = 1'b0;
    end

    // Register stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_a <= `CTL_RESET;
            ctl_b <= `CTL_RESET;
            latch_a <= `LATCH_RESET;
            latch_b <= `LATCH_RESET;
            flags <= `INT_RESET;
            mask <= `INT_RESET;
            load_a <= 1'b0;
            load_b <= 1'b0;
            wr_idx <= 16'h0000;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rresp <= `RESP_OKAY;
            rdata <= 32'h0000_0000;
        end else begin
            ctl_a <= next_ctl_a;
            ctl_b <= next_ctl_b;
            latch_a <= next_latch_a;
            latch_b <= next_latch_b;
            flags <= next_flags;
            mask <= next_mask;
            load_a <= next_load_a;
            load_b <= next_load_b;
            wr_idx <= next_wr_idx;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
        end
    end

    // ----------------------------------------
    // Control outputs
    // ----------------------------------------
    // Taken straight from control flops so they change with the write
    assign timer_a_output_pin_oe = ctl_a[`CTL_OUT_EN];
    assign timer_b_output_pin_oe = ctl_b[`CTL_OUT_EN];
    assign tod_freq_50hz = ctl_a[`CTL_A_TOD_50HZ];
    assign serial_port_output = ctl_a[`CTL_A_SERIAL_OUT];
    assign tod_write_alarm = ctl_b[`CTL_B_ALARM];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence icr_write_s;
        write_go && wr_strb[0] && (wr_idx == `IDX_INT_STATUS_MASK);
    endsequence

    flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        under_a |=> flags[`INT_TIMER_A])
        else $error("timer A underflow did not set its flag");
    handshake_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(handshake_flag_input) ##3 1'b1 |-> flags[`INT_HANDSHAKE] || $past(icr_read))
        else $error("handshake edge not latched in bit 4");
    any_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        icr_read |=> rdata[`INT_ANY] == $past(any_pending) && rdata[4:0] == $past(flags))
        else $error("interrupt read does not show flags and summary");
    mask_update_a: assert property (@(posedge aclk) disable iff (!aresetn)
        icr_write_s |=> mask == ($past(wr_data[7])
            ? ($past(mask) | $past(wr_data[4:0])) : ($past(mask) & ~$past(wr_data[4:0]))))
        else $error("mask set/clear wrong");
    write_keeps_flags_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (icr_write_s and !read_go) |=> (flags & ~$past(flags)) == '0 || $past(under_a
            || under_b || serial_event || flag_fall))
        else $error("mask write changed the flags");
    oneshot_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (under_a && ctl_a[`CTL_ONE_SHOT] && !write_go) |=> !ctl_a[`CTL_START])
        else $error("one-shot timer kept running");
    force_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (write_go && wr_strb[0] && wr_idx == `IDX_TIMER_CONTROL_A && wr_data[4])
            |=> load_a ##1 !load_a && !ctl_a[`CTL_FORCE_LOAD])
        else $error("force load not a single strobe");
    cascade_b_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (src_b == SRC_TA_UNDER && !under_a && !load_b) |=> $stable(count_b))
        else $error("timer B counted without a timer A underflow");
    bus_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        read_go |=> rvalid && !arready)
        else $error("read answer missing");

endmodule // dual_timer_interrupt_control

/* hw/dual_timer_map.svh */
/*
 * Register indexes, field positions, reset values and bus codes for the
 * dual interval timer and interrupt control block.
 * Assumes byte address = 4 * index on a 32-bit AXI4-Lite slave.
 */
`ifndef DUAL_TIMER_MAP_SVH
`define DUAL_TIMER_MAP_SVH

// ----------------------------------------
// Register indexes
// ----------------------------------------
`define IDX_TIMER_LATCH_A 16'hDD04
`define IDX_TIMER_LATCH_B 16'hDD06
`define IDX_INT_STATUS_MASK 16'hDD0D
`define IDX_TIMER_CONTROL_A 16'hDD0E
`define IDX_TIMER_CONTROL_B 16'hDD0F

// ----------------------------------------
// Interrupt register fields
// ----------------------------------------
`define INT_TIMER_A 0
`define INT_TIMER_B 1
`define INT_SERIAL 3
`define INT_HANDSHAKE 4
`define INT_ANY 7
`define INT_NON_MASKABLE 5'h10

// ----------------------------------------
// Control register fields (A and B share bits 4..0)
// ----------------------------------------
`define CTL_START 0
`define CTL_OUT_EN 1
`define CTL_TOGGLE 2
`define CTL_ONE_SHOT 3
`define CTL_FORCE_LOAD 4
`define CTL_A_CNT_SRC 5
`define CTL_A_SERIAL_OUT 6
`define CTL_A_TOD_50HZ 7
`define CTL_B_SRC_LO 5
`define CTL_B_SRC_HI 6
`define CTL_B_ALARM 7

// ----------------------------------------
// Reset values and bus codes
// ----------------------------------------
`define CTL_RESET 8'h00
`define INT_RESET 5'h00
`define LATCH_RESET 16'hFFFF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* hw/dual_timer_pkg.sv */
/*
 * Types shared by the dual interval timer block.
 * Assumes the constants in dual_timer_map.svh.
 */
package dual_timer_pkg;

    // Timer B count source selection
    typedef enum logic [1:0] {
        SRC_CLOCK = 2'b00,
        SRC_CNT_PIN = 2'b01,
        SRC_TA_UNDER = 2'b10,
        SRC_TA_UNDER_CNT = 2'b11
    } b_source_t;

    typedef logic [15:0] word16_t;
    typedef logic [7:0] reg8_t;
    typedef logic [4:0] int_bits_t;

endpackage

/* hw/interval_timer.sv */
/*
 * One down-counting interval timer with reload latch and pin output.
 * Assumes force_load is a single-cycle pulse on aclk; count_event may stay high and counts on every such cycle.
 */
`timescale 1ns/100ps

module interval_timer #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic run,
    input wire logic force_load,
    input wire logic toggle_mode,
    input wire logic count_event,
    input wire logic [WIDTH-1:0] reload_value,
    // Status
    output logic [WIDTH-1:0] count,
    output logic underflow,
    output logic pin_level
);
    logic [WIDTH-1:0] next_count;
    logic next_underflow;
    logic next_pin_level;

    // ----------------------------------------
    // Counter next state
    // ----------------------------------------
    always_comb begin
        next_count = count;
        next_underflow = 1'b0;
        next_pin_level = toggle_mode ? pin_level : 1'b0; // Pulse mode lasts one cycle
        if (force_load) begin
            next_count = reload_value;
        end else if (run && count_event) begin
            if (count == '0) begin
                next_count = reload_value;
                next_underflow = 1'b1;
                next_pin_level = toggle_mode ? ~pin_level : 1'b1;
            end else begin
                next_count = count - 1'b1;
            end
        end
    end

    // Register stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= {WIDTH{1'b1}};
            underflow <= 1'b0;
            pin_level <= 1'b0;
        end else begin
            count <= next_count;
            underflow <= next_underflow;
            pin_level <= next_pin_level;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence zero_event_s;
        run && count_event && (count == '0) && !force_load;
    endsequence

    underflow_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
        zero_event_s |=> underflow && (count == $past(reload_value)))
        else $error("underflow did not reload the counter");
    force_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        force_load |=> (count == $past(reload_value)) && !underflow)
        else $error("force load did not take the latch");
    stop_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!run && !force_load) |=> $stable(count) && !underflow)
        else $error("stopped timer changed its count");
    decrement_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (run && count_event && !force_load && count != '0) |=> count == $past(count) - 1'b1)
        else $error("timer did not decrement by one");
    toggle_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (zero_event_s and toggle_mode) |=> pin_level != $past(pin_level))
        else $error("toggle mode did not flip the pin");

endmodule // interval_timer

/* sim/dual_timer_interrupt_control_test.sv */
/*
 * Self-checking bench for the dual timer and interrupt control block.
 * Assumes host_bus_model as bus master and the register map header.
 */
`timescale 1ns/100ps
`include "dual_timer_map.svh"

module dual_timer_interrupt_control_test;
    import dual_timer_pkg::*;
    logic aclk = 0, aresetn = 0, count_input_pin = 0, handshake_flag_input = 1;
    logic serial_event = 0, hang, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, ta_pin, ta_oe, tb_pin, tb_oe, tod50, ser_out, alarm;
    logic [17:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] v;
    int error_cnt = 0, comparisons = 0, seed = 26, cyc = 0, n_ld, t0, t1, t2;

    // ----------------------------------------
    // Clock, cycle count and instances
    // ----------------------------------------
    always #5 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    // A stalled bus ends the run
    always @(posedge hang) begin
        error_cnt++;
        report_and_stop();
    end
    host_bus_model u_host_bus_model (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .hang(hang));
    dual_timer_interrupt_control u_dual_timer_interrupt_control (.aclk(aclk),
        .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .count_input_pin(count_input_pin), .serial_event(serial_event),
        .handshake_flag_input(handshake_flag_input), .timer_a_output_pin(ta_pin),
        .timer_a_output_pin_oe(ta_oe), .timer_b_output_pin(tb_pin),
        .timer_b_output_pin_oe(tb_oe), .tod_freq_50hz(tod50), .serial_port_output(ser_out),
        .tod_write_alarm(alarm));

    // ----------------------------------------
    // Checks and expectations
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] icr(input logic [4:0] fl, input logic [4:0] mk);
        return {24'h0, |(fl & (mk | 5'h10)), 2'b00, fl};
    endfunction
    task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
        u_host_bus_model.rd(idx, d, resp);
        chk(d, exp);
    endtask
    // Bounded wait for a change on a timer pin; returns the cycle seen
    task automatic wait_chg(input int sel, output int t);
        logic v0;
        v0 = sel ? tb_pin : ta_pin;
        for (int k = 0; k < 1000; k++) begin
            @(posedge aclk);
            if ((sel ? tb_pin : ta_pin) !== v0) begin
                t = cyc;
                return;
            end
        end
        error_cnt++;
        report_and_stop();
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(`IDX_INT_STATUS_MASK, 32'h0);
        rdc(16'h0000, 32'h0);
        chk(32'(resp), 32'(`RESP_SLVERR));
        u_host_bus_model.wr(16'h0000, 32'h0, resp);
        chk(32'(resp), 32'(`RESP_SLVERR));
        // Corner value first, then random control settings
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 8'hC2 : (8'($random(seed)) & 8'hC2);
            u_host_bus_model.wr(`IDX_TIMER_CONTROL_A, {24'h0, v}, resp);
            u_host_bus_model.wr(`IDX_TIMER_CONTROL_B, {24'h0, v & 8'h82}, resp);
            chk({tod50, ser_out, ta_oe, alarm, tb_oe}, {v[7], v[6], v[1], v[7], v[1]});
            rdc(`IDX_TIMER_CONTROL_A, {24'h0, v});
        end
        u_host_bus_model.wr(`IDX_INT_STATUS_MASK, 32'h83, resp);
        u_host_bus_model.wr(`IDX_INT_STATUS_MASK, 32'h02, resp);
        n_ld = 3 + ($unsigned($random(seed)) % 8);
        u_host_bus_model.wr(`IDX_TIMER_LATCH_A, 32'(n_ld), resp);
        u_host_bus_model.wr(`IDX_TIMER_CONTROL_A, 32'h13, resp);
        wait_chg(0, t1);
        wait_chg(0, t0);
        chk(32'(t0 - t1), 32'd1);
        wait_chg(0, t2);
        chk(32'(t2 - t1), 32'(n_ld + 1));
        u_host_bus_model.wr(`IDX_TIMER_CONTROL_A, 32'h0, resp);
        u_host_bus_model.rd(`IDX_TIMER_LATCH_A, d, resp);
        repeat (5) @(posedge aclk);
        rdc(`IDX_TIMER_LATCH_A, d);
        rdc(`IDX_INT_STATUS_MASK, icr(5'h01, 5'h01));
        rdc(`IDX_INT_STATUS_MASK, 32'h0);
        u_host_bus_model.wr(`IDX_TIMER_CONTROL_A, 32'h17, resp);
        wait_chg(0, t1);
        wait_chg(0, t2);
        chk(32'(t2 - t1), 32'(n_ld + 1));
        // Timer B counts timer A underflows, two per period
        u_host_bus_model.wr(`IDX_TIMER_LATCH_B, 32'h1, resp);
        u_host_bus_model.wr(`IDX_TIMER_CONTROL_A, 32'h13, resp);
        u_host_bus_model.wr(`IDX_TIMER_CONTROL_B, {25'h0, SRC_TA_UNDER, 5'h13}, resp);
        wait_chg(1, t1);
        wait_chg(1, t0);
        wait_chg(1, t2);
        chk(32'(t2 - t1), 32'(2 * (n_ld + 1)));
        u_host_bus_model.wr(`IDX_TIMER_CONTROL_B, 32'h0, resp);
        // Stop A first so no stale pulse is taken for the one-shot underflow
        u_host_bus_model.wr(`IDX_TIMER_CONTROL_A, 32'h0, resp);
        u_host_bus_model.wr(`IDX_TIMER_CONTROL_A, 32'h1B, resp);
        wait_chg(0, t1);
        repeat (4) @(posedge aclk);
        rdc(`IDX_TIMER_CONTROL_A, 32'h0A);
        u_host_bus_model.rd(`IDX_INT_STATUS_MASK, d, resp);
        // Three count pin edges underflow a latch of two; B sees it with the pin high
        u_host_bus_model.wr(`IDX_TIMER_LATCH_A, 32'h2, resp);
        u_host_bus_model.wr(`IDX_TIMER_CONTROL_A, 32'h31, resp);
        u_host_bus_model.wr(`IDX_TIMER_LATCH_B, 32'h0, resp);
        u_host_bus_model.wr(`IDX_TIMER_CONTROL_B, {25'h0, SRC_TA_UNDER_CNT, 5'h11}, resp);
        repeat (3) begin
            @(posedge aclk) count_input_pin <= 1'b1;
            repeat (3) @(posedge aclk);
            count_input_pin <= 1'b0;
            repeat (3) @(posedge aclk);
        end
        repeat (6) @(posedge aclk);
        rdc(`IDX_INT_STATUS_MASK, icr(5'h03, 5'h01));
        u_host_bus_model.wr(`IDX_TIMER_CONTROL_A, 32'h0, resp);
        serial_event <= 1'b1;
        @(posedge aclk);
        serial_event <= 1'b0;
        handshake_flag_input <= 1'b0;
        repeat (8) @(posedge aclk);
        rdc(`IDX_INT_STATUS_MASK, icr(5'h18, 5'h01));
        report_and_stop();
    end
endmodule // dual_timer_interrupt_control_test

/* sim/host_bus_model.sv */
/*
 * Host side of the register bus: AXI4-Lite master with write and read tasks.
 * Assumes a slave on aclk that answers each request; a stall raises hang.
 */
`timescale 1ns/100ps

module host_bus_model (
    // Clock
    input wire logic aclk,
    // Write channels
    output logic [17:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // Read channels
    output logic [17:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready,
    // Stall flag
    output logic hang
);
    // Idle bus at time zero
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready, hang} = '0;
        wstrb = 4'hF;
    end

    // Write: address and data offered together, held until each is taken
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                return;
            end
        end
        hang <= 1'b1;
    endtask

    // Read: a read of the interrupt register also clears its flags
    task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
                return;
            end
        end
        hang <= 1'b1;
    endtask
endmodule // host_bus_model
